// ==== pcp_pixel_clock_ctrl.sv ====
// Pixel clock PLL control: register file, sync conditioning, feedback
// divider, phase comparator and level settings for the three channels.
// Assumes the serial control interface presents single-cycle register
// strobes on clk, and that all pins are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module pcp_pixel_clock_ctrl (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Register port from the serial control interface
	input  wire logic [7:0]        regAddr,
	input  wire logic [7:0]        regWriteData,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic      [7:0]        regReadData,
	// Sync and clock pins
	input  wire logic              lineSyncIn,
	input  wire logic              pllHoldoverInput,
	input  wire logic              greenEmbeddedSyncInput,
	input  wire logic              externalClockSelect,
	input  wire logic              externalPixelMark,
	// Loop controls
	output logic                   feedbackPulse,
	output logic                   pumpUp,
	output logic                   pumpDown,
	output logic                   holdoverActive,
	output logic                   vcoRegionBitHigh,
	output logic                   vcoRegionBitLow,
	output logic                   pumpCurrentBit2,
	output logic                   pumpCurrentBit1,
	output logic                   pumpCurrentBit0,
	output logic      [10:0]       pumpCurrentMicroamps,
	output logic      [7:0]        vcoRangeLowMhz,
	output logic      [7:0]        vcoRangeHighMhz,
	// Phase shifted outputs
	output logic                   sampleClockMark,
	output logic                   alignedLineSyncOutput,
	// Channel levels, index 0 red, 1 green, 2 blue
	output logic [2:0][7:0]        channelFullScale,
	output logic [2:0][6:0]        channelLevelShift,
	output logic [2:0][16:0]       channelOffsetScaled,
	// Sync on green slicing
	output logic      [7:0]        sogTriggerLevel,
	output logic                   greenSyncDetected
);
	// Register storage
	logic [7:0]       pllDividerUpper;
	logic [3:0]       pllDividerLower;
	logic [2:0][7:0]  fullScale;
	logic [2:0][6:0]  levelShift;
	logic [7:0]       sogLevel;
	logic [7:0]       vcoRegionSetting;
	logic [2:0]       pumpCurrentSelect;
	logic [4:0]       samplingPhaseSelect;
	logic             lineActiveHigh;
	logic             holdoverActiveHigh;

	// Pin synchronisers: meta stage feeds only the sync stage
	logic [4:0]       pinMeta;
	logic [4:0]       pinSync;

	// Derived sync state
	logic             lineActive;
	logic             lineActiveDelayed;
	logic             lineLeading;
	logic             referenceEdge;
	logic [11:0]      divider;
	logic [11:0]      feedbackCount;
	logic             feedbackTerminal;
	pcp_pkg::pcp_cmp_type next_compare;
	pcp_pkg::pcp_cmp_type compareResult;

	pcp_shift_if      shiftBus ();

	// Register writes at the documented offsets
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pllDividerUpper     <= pcp_pkg::RST_DIV_UPPER;
			pllDividerLower     <= pcp_pkg::RST_DIV_LOWER;
			fullScale           <= {3{pcp_pkg::RST_FULL_SCALE}};
			levelShift          <= {3{pcp_pkg::RST_LEVEL}};
			sogLevel            <= pcp_pkg::RST_SOG_LEVEL;
			vcoRegionSetting    <= {6'h00, pcp_pkg::RST_VCO};
			pumpCurrentSelect   <= pcp_pkg::RST_PUMP;
			samplingPhaseSelect <= pcp_pkg::RST_PHASE;
			lineActiveHigh      <= pcp_pkg::RST_POLARITY[pcp_pkg::POL_LINE_BIT];
			holdoverActiveHigh  <= pcp_pkg::RST_POLARITY[pcp_pkg::POL_HOLD_BIT];
		end else if (regWrite) begin
			case (regAddr)
				pcp_pkg::ADDR_DIV_UPPER: begin
					pllDividerUpper <= regWriteData;
				end
				pcp_pkg::ADDR_DIV_LOWER: begin
					pllDividerLower <= regWriteData[pcp_pkg::DIV_LOWER_MSB:
						pcp_pkg::DIV_LOWER_LSB];
				end
				pcp_pkg::ADDR_VCO_REGION: begin
					vcoRegionSetting <= regWriteData;
				end
				pcp_pkg::ADDR_PUMP_CURRENT: begin
					pumpCurrentSelect <= regWriteData[2:0];
				end
				pcp_pkg::ADDR_PHASE: begin
					samplingPhaseSelect <= regWriteData[4:0];
				end
				pcp_pkg::ADDR_RED_SCALE: begin
					fullScale[0] <= regWriteData;
				end
				pcp_pkg::ADDR_GREEN_SCALE: begin
					fullScale[1] <= regWriteData;
				end
				pcp_pkg::ADDR_BLUE_SCALE: begin
					fullScale[2] <= regWriteData;
				end
				pcp_pkg::ADDR_RED_SHIFT: begin
					levelShift[0] <= regWriteData[6:0];
				end
				pcp_pkg::ADDR_GREEN_SHIFT: begin
					levelShift[1] <= regWriteData[6:0];
				end
				pcp_pkg::ADDR_BLUE_SHIFT: begin
					levelShift[2] <= regWriteData[6:0];
				end
				pcp_pkg::ADDR_SOG_LEVEL: begin
					sogLevel <= regWriteData;
				end
				pcp_pkg::ADDR_POLARITY: begin
					lineActiveHigh     <= regWriteData[pcp_pkg::POL_LINE_BIT];
					holdoverActiveHigh <= regWriteData[pcp_pkg::POL_HOLD_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Register reads, answered one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			regReadData <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				pcp_pkg::ADDR_REVISION:     regReadData <= pcp_pkg::REVISION_CODE;
				pcp_pkg::ADDR_DIV_UPPER:    regReadData <= pllDividerUpper;
				pcp_pkg::ADDR_DIV_LOWER:    regReadData <= {pllDividerLower, 4'h0};
				pcp_pkg::ADDR_VCO_REGION:   regReadData <= vcoRegionSetting;
				pcp_pkg::ADDR_PUMP_CURRENT: regReadData <= {5'h00, pumpCurrentSelect};
				pcp_pkg::ADDR_PHASE:        regReadData <= {3'h0, samplingPhaseSelect};
				pcp_pkg::ADDR_RED_SCALE:    regReadData <= fullScale[0];
				pcp_pkg::ADDR_GREEN_SCALE:  regReadData <= fullScale[1];
				pcp_pkg::ADDR_BLUE_SCALE:   regReadData <= fullScale[2];
				pcp_pkg::ADDR_RED_SHIFT:    regReadData <= {1'b0, levelShift[0]};
				pcp_pkg::ADDR_GREEN_SHIFT:  regReadData <= {1'b0, levelShift[1]};
				pcp_pkg::ADDR_BLUE_SHIFT:   regReadData <= {1'b0, levelShift[2]};
				pcp_pkg::ADDR_SOG_LEVEL:    regReadData <= sogLevel;
				pcp_pkg::ADDR_POLARITY:     regReadData <= {6'h00, holdoverActiveHigh,
					lineActiveHigh};
				pcp_pkg::ADDR_STATUS:       regReadData <= {2'h0, compareResult == pcp_pkg::CMP_UP,
					compareResult == pcp_pkg::CMP_DOWN, greenSyncDetected,
					pinSync[3], holdoverActive, lineActive};
				default:                    regReadData <= 8'h00; // Unmapped reads zero
			endcase
		end
	end

	// Two-stage synchronisers for all pins; holdover is synchronised like the rest
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pinMeta <= 5'h00;
			pinSync <= 5'h00;
		end else begin
			pinMeta <= {externalPixelMark, externalClockSelect, greenEmbeddedSyncInput,
				pllHoldoverInput, lineSyncIn};
			pinSync <= pinMeta;
		end
	end

	// Polarity normalisation of line sync and holdover
	assign lineActive     = lineActiveHigh ? pinSync[0] : ~pinSync[0];
	assign holdoverActive = holdoverActiveHigh ? pinSync[1] : ~pinSync[1];

	// Green embedded sync is active low only
	assign greenSyncDetected = ~pinSync[2];
	assign sogTriggerLevel   = sogLevel;

	// Leading edge of normalised line sync
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lineActiveDelayed <= 1'b0;
		end else begin
			lineActiveDelayed <= lineActive;
		end
	end
	assign lineLeading = lineActive & ~lineActiveDelayed;

	// Holdover or external clock blocks the reference to the comparator
	assign referenceEdge = lineLeading & ~holdoverActive & ~pinSync[3];

	// Twelve-bit divider assembled from both bytes
	assign divider = {pllDividerUpper, pllDividerLower};

	// Feedback counter runs on through holdover and reloads at terminal count
	assign feedbackTerminal = (feedbackCount >= divider);
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			feedbackCount <= 12'h000;
		end else if (pinSync[3]) begin
			feedbackCount <= 12'h000;
		end else if (feedbackTerminal) begin
			feedbackCount <= 12'h000;
		end else begin
			feedbackCount <= feedbackCount + 12'h001;
		end
	end

	// One divided-clock pulse per divider plus one cycles
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			feedbackPulse <= 1'b0;
		end else begin
			feedbackPulse <= feedbackTerminal & ~pinSync[3];
		end
	end

	// Phase comparison of divided clock against line sync
	always_comb begin
		next_compare = pcp_pkg::CMP_IDLE;
		if (referenceEdge) begin
			if (feedbackTerminal) begin
				next_compare = pcp_pkg::CMP_IDLE; // In phase
			end else if (feedbackCount <= {1'b0, divider[11:1]}) begin
				next_compare = pcp_pkg::CMP_DOWN; // Divided clock early, slow VCO
			end else begin
				next_compare = pcp_pkg::CMP_UP; // Divided clock late, speed VCO
			end
		end
	end

	// Comparator result held for one cycle per reference edge
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			compareResult <= pcp_pkg::CMP_IDLE;
		end else begin
			compareResult <= next_compare;
		end
	end

	// Pump drive pulses from comparator result
	always_comb begin
		case (compareResult)
			pcp_pkg::CMP_UP: begin
				pumpUp   = 1'b1;
				pumpDown = 1'b0;
			end
			pcp_pkg::CMP_DOWN: begin
				pumpUp   = 1'b0;
				pumpDown = 1'b1;
			end
			default: begin
				pumpUp   = 1'b0;
				pumpDown = 1'b0;
			end
		endcase
	end

	// VCO region uses the two low bits only
	assign vcoRegionBitHigh = vcoRegionSetting[1];
	assign vcoRegionBitLow  = vcoRegionSetting[0];
	assign vcoRangeLowMhz   = pcp_pkg::vco_low_mhz(vcoRegionSetting[1:0]);
	assign vcoRangeHighMhz  = pcp_pkg::vco_high_mhz(vcoRegionSetting[1:0]);

	// Charge pump current selection
	assign pumpCurrentBit2      = pumpCurrentSelect[2];
	assign pumpCurrentBit1      = pumpCurrentSelect[1];
	assign pumpCurrentBit0      = pumpCurrentSelect[0];
	assign pumpCurrentMicroamps = pcp_pkg::pump_microamps(pumpCurrentSelect);

	// Channel full scale, offset code and range-scaled offset
	assign channelFullScale  = fullScale;
	assign channelLevelShift = levelShift;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			channelOffsetScaled <= '0;
		end else begin
			for (int ch = 0; ch < 3; ch++) begin
				channelOffsetScaled[ch] <= pcp_pkg::level_scaled(levelShift[ch],
					fullScale[ch]);
			end
		end
	end

	// Phase shifter source: internal divided clock or external pixel mark
	assign shiftBus.phaseSelect = samplingPhaseSelect;
	assign shiftBus.pixelMark   = pinSync[3] ? pinSync[4] : feedbackPulse;
	assign shiftBus.lineSync    = lineActive;

	pcp_phase_shifter phaseShifter (
		.clk     (clk),
		.reset_n (reset_n),
		.shift   (shiftBus)
	);

	// Registered shifted outputs
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sampleClockMark       <= 1'b0;
			alignedLineSyncOutput <= 1'b0;
		end else begin
			sampleClockMark       <= shiftBus.shiftedMark;
			alignedLineSyncOutput <= shiftBus.shiftedLineSync;
		end
	end
endmodule : pcp_pixel_clock_ctrl
`default_nettype wire

// ==== pcp_pkg.sv ====
// Constants, register map and decode functions of the pixel clock control.
// Assumes an 8-bit register port fed by the serial control interface.
`default_nettype none
package pcp_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_REVISION     = 8'h00;
	localparam logic [7:0] ADDR_DIV_UPPER    = 8'h01;
	localparam logic [7:0] ADDR_DIV_LOWER    = 8'h02;
	localparam logic [7:0] ADDR_VCO_REGION   = 8'h03;
	localparam logic [7:0] ADDR_PUMP_CURRENT = 8'h04;
	localparam logic [7:0] ADDR_PHASE        = 8'h05;
	localparam logic [7:0] ADDR_RED_SCALE    = 8'h08;
	localparam logic [7:0] ADDR_GREEN_SCALE  = 8'h09;
	localparam logic [7:0] ADDR_RED_SHIFT    = 8'h0B;
	localparam logic [7:0] ADDR_GREEN_SHIFT  = 8'h0C;
	localparam logic [7:0] ADDR_BLUE_SHIFT   = 8'h0D;
	localparam logic [7:0] ADDR_BLUE_SCALE   = 8'h10;
	localparam logic [7:0] ADDR_SOG_LEVEL    = 8'h11;
	localparam logic [7:0] ADDR_POLARITY     = 8'h12;
	localparam logic [7:0] ADDR_STATUS       = 8'h13;

	// Field positions
	localparam int DIV_LOWER_MSB  = 7;
	localparam int DIV_LOWER_LSB  = 4;
	localparam int POL_LINE_BIT   = 0;
	localparam int POL_HOLD_BIT   = 1;

	// Reset values
	localparam logic [7:0] RST_DIV_UPPER  = 8'h69;
	localparam logic [3:0] RST_DIV_LOWER  = 4'hD;
	localparam logic [7:0] RST_FULL_SCALE = 8'h80;
	localparam logic [6:0] RST_LEVEL      = 7'h40;
	localparam logic [7:0] RST_SOG_LEVEL  = 8'h0F;
	localparam logic [1:0] RST_VCO        = 2'h0;
	localparam logic [2:0] RST_PUMP       = 3'h0;
	localparam logic [4:0] RST_PHASE      = 5'h00;
	localparam logic [1:0] RST_POLARITY   = 2'h3;

	// Arbitrary revision value
	localparam logic [7:0] REVISION_CODE  = 8'hA5;

	// Phase shifter geometry
	localparam int PHASE_STEPS            = 32;
	localparam int PHASE_WIDTH            = 5;

	// Offset code of zero shift
	localparam logic [6:0] LEVEL_CENTER   = 7'h40;

	// Phase comparator result
	typedef enum {CMP_IDLE, CMP_UP, CMP_DOWN} pcp_cmp_type;

	// Loop filter drive current in microamps
	function automatic logic [10:0] pump_microamps(input logic [2:0] code);
		case (code)
			3'h0:    pump_microamps = 11'd50;
			3'h1:    pump_microamps = 11'd100;
			3'h2:    pump_microamps = 11'd150;
			3'h3:    pump_microamps = 11'd250;
			3'h4:    pump_microamps = 11'd350;
			3'h5:    pump_microamps = 11'd500;
			3'h6:    pump_microamps = 11'd750;
			default: pump_microamps = 11'd1500;
		endcase
	endfunction : pump_microamps

	// Lower bound of the VCO region in MHz
	function automatic logic [7:0] vco_low_mhz(input logic [1:0] code);
		case (code)
			2'h0:    vco_low_mhz = 8'd10;
			2'h1:    vco_low_mhz = 8'd41;
			2'h2:    vco_low_mhz = 8'd82;
			default: vco_low_mhz = 8'd150;
		endcase
	endfunction : vco_low_mhz

	// Upper bound of the VCO region in MHz, zero means open ended
	function automatic logic [7:0] vco_high_mhz(input logic [1:0] code);
		case (code)
			2'h0:    vco_high_mhz = 8'd41;
			2'h1:    vco_high_mhz = 8'd82;
			2'h2:    vco_high_mhz = 8'd150;
			default: vco_high_mhz = 8'd0;
		endcase
	endfunction : vco_high_mhz

	// Signed offset steps, clipped to plus or minus 63
	function automatic logic signed [6:0] level_steps(input logic [6:0] code);
		logic [6:0] diff;
		diff = code - LEVEL_CENTER;
		if (code == 7'h00)
			level_steps = -7'sd63;
		else
			level_steps = $signed(diff);
	endfunction : level_steps

	// Offset in quarter-range units: steps times a span tracking full scale
	function automatic logic signed [16:0] level_scaled(input logic [6:0] code,
		input logic [7:0] scale);
		logic signed [16:0] steps;
		logic signed [16:0] span;
		steps = 17'(level_steps(code));
		span = $signed({8'h00, 1'b1, scale});
		level_scaled = 17'(steps * span);
	endfunction : level_scaled

endpackage : pcp_pkg
`default_nettype wire

// ==== pcp_shift_if.sv ====
// Carrier between the control block and its phase shifter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface pcp_shift_if;
	logic [4:0] phaseSelect;
	logic       pixelMark;
	logic       lineSync;
	logic       shiftedMark;
	logic       shiftedLineSync;

	modport control (output phaseSelect, output pixelMark, output lineSync,
		input shiftedMark, input shiftedLineSync);
	modport shifter (input phaseSelect, input pixelMark, input lineSync,
		output shiftedMark, output shiftedLineSync);
endinterface : pcp_shift_if
`default_nettype wire

// ==== pcp_phase_shifter.sv ====
// Sampling phase shifter: delays pixel mark and line sync by the same tap.
// Assumes synchronous inputs on clk; one tap stands for one phase step.
`timescale 1ns/100ps
`default_nettype none
module pcp_phase_shifter (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Control side
	pcp_shift_if.shifter shift
);
	logic [pcp_pkg::PHASE_STEPS-1:0] markLine;
	logic [pcp_pkg::PHASE_STEPS-1:0] syncLine;

	// Two matched delay lines read at one tap so both signals see identical shift
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			markLine <= '0;
			syncLine <= '0;
		end else begin
			markLine <= {markLine[pcp_pkg::PHASE_STEPS-2:0], shift.pixelMark};
			syncLine <= {syncLine[pcp_pkg::PHASE_STEPS-2:0], shift.lineSync};
		end
	end

	// Tap zero is the undelayed input; the five-bit code wraps after 31
	always_comb begin
		if (shift.phaseSelect == 5'h00) begin
			shift.shiftedMark     = shift.pixelMark;
			shift.shiftedLineSync = shift.lineSync;
		end else begin
			shift.shiftedMark     = markLine[shift.phaseSelect - 5'h01];
			shift.shiftedLineSync = syncLine[shift.phaseSelect - 5'h01];
		end
	end
endmodule : pcp_phase_shifter
`default_nettype wire

// ==== pcp_ctrl_props.sv ====
// Concurrent checks on the pixel clock control ports.
// Assumes it is bound to pcp_pixel_clock_ctrl and shares its clock.
`timescale 1ns/100ps
`default_nettype none
module pcp_ctrl_props (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// Register writes
	input wire logic [7:0]  regAddr,
	input wire logic [7:0]  regWriteData,
	input wire logic        regWrite,
	// Pins
	input wire logic        pllHoldoverInput,
	input wire logic        greenEmbeddedSyncInput,
	input wire logic        externalClockSelect,
	// Loop outputs
	input wire logic        feedbackPulse,
	input wire logic        pumpUp,
	input wire logic        pumpDown,
	input wire logic        holdoverActive,
	input wire logic        vcoRegionBitHigh,
	input wire logic        vcoRegionBitLow,
	input wire logic        pumpCurrentBit2,
	input wire logic        pumpCurrentBit1,
	input wire logic        pumpCurrentBit0,
	input wire logic [10:0] pumpCurrentMicroamps,
	input wire logic [7:0]  vcoRangeLowMhz,
	input wire logic [7:0]  vcoRangeHighMhz,
	input wire logic        greenSyncDetected
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [7:0]  divUpper;
	logic [3:0]  divLower;
	logic [11:0] gap;
	logic [2:0]  extCnt;
	logic [1:0]  rstCnt;
	logic        dirty;
	logic        holdHigh;
	// Shadow of divider bytes and holdover polarity
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			divUpper <= pcp_pkg::RST_DIV_UPPER;
			divLower <= pcp_pkg::RST_DIV_LOWER;
			holdHigh <= pcp_pkg::RST_POLARITY[1];
		end else if (regWrite) begin
			if (regAddr == pcp_pkg::ADDR_DIV_UPPER) divUpper <= regWriteData;
			if (regAddr == pcp_pkg::ADDR_DIV_LOWER) divLower <= regWriteData[7:4];
			if (regAddr == pcp_pkg::ADDR_POLARITY) holdHigh <= regWriteData[1];
		end
	end
	// Gap between feedback pulses; a period disturbed by writes is skipped
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			gap <= 12'h000;
			extCnt <= 3'h0;
			rstCnt <= 2'h0;
			dirty <= 1'b1;
		end else begin
			gap <= feedbackPulse ? 12'h000 : gap + 12'h001;
			extCnt <= externalClockSelect ? 3'h4 : (extCnt != 3'h0 ? extCnt - 3'h1 : 3'h0);
			rstCnt <= (rstCnt == 2'h3) ? rstCnt : rstCnt + 2'h1;
			if (regWrite || externalClockSelect || extCnt != 3'h0) dirty <= 1'b1;
			else if (feedbackPulse) dirty <= 1'b0;
		end
	end
	property p_fb_period;
		feedbackPulse && !dirty |-> gap == {divUpper, divLower};
	endproperty
	a_fb_period: assert property (p_fb_period) else $error("feedback gap wrong");
	property p_fb_single;
		feedbackPulse |=> !feedbackPulse;
	endproperty
	a_fb_single: assert property (p_fb_single) else $error("feedback pulse too long");
	property p_pump_excl;
		!(pumpUp && pumpDown);
	endproperty
	a_pump_excl: assert property (p_pump_excl) else $error("pump both ways");
	property p_pump_pulse;
		pumpUp || pumpDown |=> !pumpUp && !pumpDown;
	endproperty
	a_pump_pulse: assert property (p_pump_pulse) else $error("pump pulse too long");
	property p_hold_block;
		holdoverActive && $past(holdoverActive) |-> !pumpUp && !pumpDown;
	endproperty
	a_hold_block: assert property (p_hold_block) else $error("pump in holdover");
	property p_hold_level;
		rstCnt >= 2'h2 && $stable(pllHoldoverInput)
			&& pllHoldoverInput == $past(pllHoldoverInput, 2)
			|-> holdoverActive == (pllHoldoverInput == holdHigh);
	endproperty
	a_hold_level: assert property (p_hold_level) else $error("holdover level wrong");
	property p_green;
		rstCnt >= 2'h2 && $stable(greenEmbeddedSyncInput)
			&& greenEmbeddedSyncInput == $past(greenEmbeddedSyncInput, 2)
			|-> greenSyncDetected == !greenEmbeddedSyncInput;
	endproperty
	a_green: assert property (p_green) else $error("green sync wrong");
	property p_vco_top;
		vcoRegionBitHigh && vcoRegionBitLow |-> vcoRangeLowMhz == 8'h96 && vcoRangeHighMhz == 8'h00;
	endproperty
	a_vco_top: assert property (p_vco_top) else $error("vco region wrong");
	property p_pump_top;
		{pumpCurrentBit2, pumpCurrentBit1, pumpCurrentBit0} == 3'h7
			|-> pumpCurrentMicroamps == 11'h5DC;
	endproperty
	a_pump_top: assert property (p_pump_top) else $error("pump current wrong");
	c_period: cover property (feedbackPulse && !dirty);
	c_pump: cover property (pumpUp || pumpDown);
	c_hold: cover property (holdoverActive);
endmodule : pcp_ctrl_props
bind pcp_pixel_clock_ctrl pcp_ctrl_props u_props (.*);
`default_nettype wire

// ==== pcp_source_model.sv ====
// Graphics source: line sync, negative green sync and holdover pin.
// Assumes period counts clk cycles; zero stops the line sync.
`timescale 1ns/100ps
`default_nettype none
module pcp_source_model (
	// Clock and controls
	input  wire logic        clk,
	input  wire logic [15:0] period,
	input  wire logic        lineHigh,
	input  wire logic        holdReq,
	input  wire logic        holdHigh,
	// Pins towards the device
	output logic             lineSyncIn,
	output logic             pllHoldoverInput,
	output logic             greenEmbeddedSyncInput
);
	logic [15:0] count = 16'hFFFF;
	// Line counter, eight-cycle sync pulse at its start
	always @(posedge clk) begin
		if (period == 16'h0000) count <= 16'hFFFF;
		else if (count >= period - 16'h0001) count <= 16'h0000;
		else count <= count + 16'h0001;
	end
	// Pin levels follow the requested polarities
	assign lineSyncIn = !((count < 16'h0008) ^ lineHigh);
	assign greenEmbeddedSyncInput = !(count < 16'h0008);
	assign pllHoldoverInput = !(holdReq ^ holdHigh);
endmodule : pcp_source_model
`default_nettype wire

// ==== pixel_clock_pll_and_level_control_test.sv ====
// Testbench of the pixel clock control with a graphics source model.
// Assumes the register port strobes and the 10 MHz clock of the notes.
`timescale 1ns/100ps
`default_nettype none
module pixel_clock_pll_and_level_control_test;
	logic clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic [7:0] regAddr = 8'h00, regWriteData = 8'h00, regReadData, sogTriggerLevel;
	logic externalClockSelect = 1'b0, externalPixelMark = 1'b0, feedbackPulse;
	logic lineSyncIn, pllHoldoverInput, greenEmbeddedSyncInput, pumpUp, pumpDown;
	logic holdoverActive, vcoRegionBitHigh, vcoRegionBitLow, pumpCurrentBit2, greenSyncDetected;
	logic pumpCurrentBit1, pumpCurrentBit0, sampleClockMark, alignedLineSyncOutput;
	logic [10:0] pumpCurrentMicroamps;
	logic [7:0] vcoRangeLowMhz, vcoRangeHighMhz;
	logic [2:0][7:0] channelFullScale;
	logic [2:0][6:0] channelLevelShift;
	logic [2:0][16:0] channelOffsetScaled;
	logic [15:0] period = 16'h0000;
	logic lineHigh = 1'b1, holdReq = 1'b0, holdHigh = 1'b1;
	int err_total = 0, comparisons = 0, n, n0, m, m0, k;
	logic [7:0] addrs [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09,
		8'h0B, 8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h20};
	logic [7:0] vals [15] = '{pcp_pkg::REVISION_CODE, 8'h69, 8'hD0, 8'h00, 8'h00, 8'h00,
		8'h80, 8'h80, 8'h40, 8'h40, 8'h40, 8'h80, 8'h0F, 8'h03, 8'h00};
	logic [7:0] scA [3] = '{8'h08, 8'h09, 8'h10};
	logic [7:0] shA [3] = '{8'h0B, 8'h0C, 8'h0D};
	logic [7:0] scV [3] = '{8'hFF, 8'h00, 8'h80};
	logic [6:0] shV [3] = '{7'h7F, 7'h00, 7'h40};
	logic [7:0] vLo [4] = '{8'h0A, 8'h29, 8'h52, 8'h96};
	logic [7:0] vHi [4] = '{8'h29, 8'h52, 8'h96, 8'h00};
	logic [10:0] pA [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA, 11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};
	logic [4:0] ph [3] = '{5'h00, 5'h01, 5'h1F};

	pcp_pixel_clock_ctrl DUT (.*);
	pcp_source_model u_source (.clk(clk), .period(period), .lineHigh(lineHigh),
		.holdReq(holdReq), .holdHigh(holdHigh), .lineSyncIn(lineSyncIn),
		.pllHoldoverInput(pllHoldoverInput), .greenEmbeddedSyncInput(greenEmbeddedSyncInput));

	// Clock
	always #50 clk = ~clk;

	task automatic final_report();
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chkn(input string what, input int exp, input int got);
		comparisons++;
		if (got != exp) begin
			err_total++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chkn
	// Register write, one-cycle strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr
	// Register read, data checked one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 chk($sformatf("register %h", a), {9'h000, e}, {9'h000, regReadData});
	endtask : rd
	// Cycles from an external pixel mark to the shifted mark
	task automatic markLat(output int c);
		@(posedge clk);
		externalPixelMark <= 1'b1;
		@(posedge clk);
		externalPixelMark <= 1'b0;
		#1 c = 1;
		while (sampleClockMark !== 1'b1 && c < 80) begin
			@(posedge clk);
			#1 c++;
		end
	endtask : markLat
	// Cycles from a fresh line sync edge to the aligned output
	task automatic lineLat(output int c);
		c = 0;
		while (lineSyncIn !== !lineHigh && c < 700) begin
			@(posedge clk);
			#1 c++;
		end
		while (lineSyncIn !== lineHigh && c < 1400) begin
			@(posedge clk);
			#1 c++;
		end
		c = 0;
		while (alignedLineSyncOutput !== 1'b1 && c < 80) begin
			@(posedge clk);
			#1 c++;
		end
	endtask : lineLat
	// Spacing of two feedback pulses
	task automatic fbGap(output int c);
		c = 0;
		while (feedbackPulse !== 1'b1 && c < 5000) begin
			@(posedge clk);
			#1 c++;
		end
		c = 0;
		do begin
			@(posedge clk);
			#1 c++;
		end while (feedbackPulse !== 1'b1 && c < 5000);
	endtask : fbGap
	task automatic countPumps(output int c);
		c = 0;
		repeat (1500) begin
			@(posedge clk);
			#1 c += int'(pumpUp === 1'b1 || pumpDown === 1'b1);
		end
	endtask : countPumps
	function automatic logic [16:0] offs(input int code, input int scale);
		offs = 17'((code == 0 ? -63 : code - 64) * (256 + scale));
	endfunction : offs

	// Watchdog
	initial begin
		#6000000;
		err_total++;
		final_report();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		period <= 16'h012C;
		for (k = 0; k < 15; k++) rd(addrs[k], vals[k]);
		wr(8'h00, 8'h00);
		rd(8'h00, pcp_pkg::REVISION_CODE);
		for (k = 0; k < 3; k++) begin
			wr(scA[k], scV[k]);
			wr(shA[k], {1'b0, shV[k]});
		end
		wr(8'h11, 8'h5A);
		repeat (3) @(posedge clk);
		#1 chk("trigger level", 17'h0005A, {9'h000, sogTriggerLevel});
		for (k = 0; k < 3; k++) begin
			chk("full scale", {9'h000, scV[k]}, {9'h000, channelFullScale[k]});
			chk("level shift", {10'h000, shV[k]}, {10'h000, channelLevelShift[k]});
			chk("scaled offset", offs(shV[k], scV[k]), channelOffsetScaled[k]);
		end
		for (k = 0; k < 4; k++) begin
			wr(8'h03, {6'h3F, 2'(k)});
			#1 chk("vco bits", 17'(k), {15'h0000, vcoRegionBitHigh, vcoRegionBitLow});
			chk("vco low", {9'h000, vLo[k]}, {9'h000, vcoRangeLowMhz});
			chk("vco high", {9'h000, vHi[k]}, {9'h000, vcoRangeHighMhz});
		end
		for (k = 0; k < 8; k++) begin
			wr(8'h04, 8'(k));
			#1 chk("pump bits", 17'(k), {14'h0000, pumpCurrentBit2, pumpCurrentBit1, pumpCurrentBit0});
			chk("pump current", {6'h00, pA[k]}, {6'h00, pumpCurrentMicroamps});
		end
		@(posedge clk) externalClockSelect <= 1'b1;
		for (k = 0; k < 3; k++) begin
			wr(8'h05, {3'h0, ph[k]});
			markLat(n);
			lineLat(m);
			if (k == 0) {n0, m0} = {n, m};
			chkn("mark delay", n0 + int'(ph[k]), n);
			chkn("line delay", m0 + int'(ph[k]), m);
		end
		wr(8'h12, 8'h02);
		lineHigh <= 1'b0;
		lineLat(m);
		chkn("low line delay", m0 + 31, m);
		lineHigh <= 1'b1;
		wr(8'h12, 8'h03);
		wr(8'h05, 8'h00);
		externalClockSelect <= 1'b0;
		wr(8'h01, 8'h0D);
		wr(8'h02, 8'hD0);
		fbGap(n);
		fbGap(n);
		chkn("feedback period", 222, n);
		period <= 16'h00C8;
		countPumps(n);
		chkn("pumps seen", 1, int'(n > 0));
		holdReq <= 1'b1;
		repeat (4) @(posedge clk);
		countPumps(n);
		chkn("holdover pumps", 0, n);
		fbGap(n);
		chkn("holdover period", 222, n);
		wr(8'h12, 8'h01);
		holdHigh <= 1'b0;
		period <= 16'h0000;
		repeat (4) @(posedge clk);
		#1 chk("holdover low", 17'h00001, {16'h0000, holdoverActive});
		rd(8'h13, 8'h02);
		holdReq <= 1'b0;
		repeat (4) @(posedge clk);
		#1 chk("holdover off", 17'h00000, {16'h0000, holdoverActive});
		final_report();
	end
endmodule : pixel_clock_pll_and_level_control_test
`default_nettype wire
